// [shared/lfal_regs.svh]
/*
  Register offsets, reset values, bus codes and timing counts of the LED
  fault alert logic. Assumes inclusion by bare name into design files.
*/
`ifndef LFAL_REGS_SVH
`define LFAL_REGS_SVH
`define LFAL_OFS_IRQ_STATUS 5'h00
`define LFAL_OFS_IRQ_MASK 5'h04
`define LFAL_OFS_OPEN_FLAGS 5'h08
`define LFAL_OFS_SHORT_FLAGS 5'h0C
`define LFAL_OFS_STATE 5'h10
`define LFAL_OFS_CONTROL 5'h14
`define LFAL_RST_MASK 5'h00
`define LFAL_RST_CONTROL 1'b1
`define LFAL_EV_OPEN 0
`define LFAL_EV_SHORT 1
`define LFAL_EV_HEAT 2
`define LFAL_EV_ARA 3
`define LFAL_EV_CLEAR 4
`define LFAL_ARA_READ 8'h19
`define LFAL_ALL_PREFIX 3'h2
`define LFAL_ONE_PREFIX 3'h5
`define LFAL_HEAT_CLEAR 8'hFF
`define LFAL_QUAL_TIME_NS 15000
`define LFAL_CLK_PERIOD_NS 25
`define LFAL_QUAL_CYCLES \
  ((`LFAL_QUAL_TIME_NS + `LFAL_CLK_PERIOD_NS - 1) / `LFAL_CLK_PERIOD_NS)
`endif

// [shared/lfal_pkg.sv]
/*
  Types of the LED fault alert logic.
  Assumes nothing of its surroundings.
*/
package lfal_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_DATA = 3'h2,
    ST_DACK = 3'h6,
    ST_TX = 3'h7,
    ST_TACK = 3'h5,
    ST_SKIP = 3'h4
  } lfal_state_type;
  typedef enum logic [2:0] {
    MD_NONE = 3'h0,
    MD_ARA = 3'h1,
    MD_ALLW = 3'h2,
    MD_ONEW = 3'h3,
    MD_ONER = 3'h4
  } lfal_mode_type;
endpackage

// [hw/lfal_qual.sv]
/*
  Persistence qualifier for one comparator indication.
  Assumes a level already synchronised to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module lfal_qual #(
  parameter int QUAL_CYCLES = 600
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Indication and result.
  input wire logic level_in,
  output logic fire_out
);
  localparam int CW = $clog2(QUAL_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(QUAL_CYCLES);
  logic [CW-1:0] count_q;
  wire done_w = (count_q == LIMIT);
  wire [CW-1:0] count_d = !level_in ? '0 :
                          done_w ? count_q : count_q + CW'(1); // [R18]

  if (QUAL_CYCLES < 1) begin : g_chk
    $error("QUAL_CYCLES must be at least one");
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign fire_out = done_w & level_in;

  timer_restart_a: assert property ( // [R18]
    @(posedge clk_in) disable iff (!reset_n_in)
    !level_in |=> !fire_out && count_q == '0)
    else $error("persistence timer did not restart");
endmodule
`default_nettype wire

// [hw/lfal_alert_logic.sv]
/*
  LED fault alert logic: qualifies fault indications, latches open and
  short flags, drives the shared open-drain alert, answers the alert
  response read and clears flags on qualifying writes at STOP.
  Assumes an Avalon-MM master on clk_in and a serial bus master on the
  SCL/SDA pins; all pin inputs are asynchronous to clk_in.
*/
// Notes on behaviour
// R1: Master finds alerter via address 0001100, read.
// R2: While alerting, acknowledge and send own address.
// R3: Lose arbitration on sent one, read zero.
// R4: After success release alert, ignore until event.
// R5: Alert response never touches fault flags.
// R6: Open fault immediate on overvoltage, else qualified.
// R7: Open fault sets flag, alert, forces switch.
// R8: Forced switch holds until channel rewritten.
// R9: Short fault after qualified persistence.
// R10: Short fault sets flag and alert only.
// R11: Only matching writes may clear channel flags.
// R12: At STOP clear if fault gone, else alert.
// R13: Overheat sets all flags, alert, forces all.
// R14: Overheat flags cleared only by all-ones write.
// R15: At STOP clear all if temperature recovered.
// R16: Channel read byte leads with open, short.
// R17: No acknowledge of alert read without alert.
// R18: Persistence timer restarts when indication drops.
// R19: Alert output only pulls low or releases.
`timescale 1ns/1ps
`default_nettype none
`include "lfal_regs.svh"
module lfal_alert_logic
  import lfal_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int QUAL_CYCLES = `LFAL_QUAL_CYCLES
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Avalon-MM register slave.
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  // Serial bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [3:0] bus_id_select_pins_in,
  // Shared alert line.
  output logic alert_n_out,
  output logic alert_oe_out,
  // Comparator and temperature indications.
  input wire logic [7:0] open_ovp_in,
  input wire logic [7:0] open_thr_in,
  input wire logic [7:0] short_thr_in,
  input wire logic overtemp_in,
  input wire logic temp_ok_in,
  // Channel switch and configuration side.
  input wire logic [5:0] read_cfg_in,
  output logic [2:0] cfg_channel_out,
  output logic [7:0] switch_force_on_out
);
  localparam int SW = 32;

  if (CHANNELS != 8) begin : g_chk
    $error("CHANNELS must be 8");
  end

  // Three-stage pin synchroniser; a change counts when the last two stages agree.
  logic [SW-1:0] s1_q, s2_q, s3_q, stab_q;
  wire [SW-1:0] raw_w = {scl_in, sda_in, bus_id_select_pins_in,
                         open_ovp_in, open_thr_in, short_thr_in,
                         overtemp_in, temp_ok_in};
  wire [SW-1:0] stab_d = (s2_q & s3_q) | (stab_q & (s2_q ^ s3_q));
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_q <= 32'hC0000000;
      s2_q <= 32'hC0000000;
      s3_q <= 32'hC0000000;
      stab_q <= 32'hC0000000;
    end else begin
      s1_q <= raw_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stab_q <= stab_d;
    end
  end
  wire scl_s = stab_q[31];
  wire sda_s = stab_q[30];
  wire [3:0] id_s = stab_q[29:26];
  wire [7:0] ovp_s = stab_q[25:18];
  wire [7:0] othr_s = stab_q[17:10];
  wire [7:0] sthr_s = stab_q[9:2];
  wire heat_s = stab_q[1];
  wire tok_s = stab_q[0];

  // Persistence qualifiers, one pair per channel.
  logic [7:0] oq_w, sq_w;
  for (genvar i = 0; i < 8; i++) begin : g_ch
    lfal_qual #(.QUAL_CYCLES(QUAL_CYCLES)) u_oq (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .level_in(othr_s[i]),
      .fire_out(oq_w[i])
    );
    lfal_qual #(.QUAL_CYCLES(QUAL_CYCLES)) u_sq (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .level_in(sthr_s[i]),
      .fire_out(sq_w[i])
    );
  end

  // Serial bus edge and condition detection.
  logic scl_p_q, sda_p_q;
  wire start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_w = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire rise_w = scl_s & ~scl_p_q;
  wire fall_w = ~scl_s & scl_p_q;

  lfal_state_type st_q, st_d;
  lfal_mode_type md_q, md_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, wdat_q, wdat_d;
  logic [2:0] wch_q, wch_d;
  logic oe_q, oe_d, pend_q, pend_d, wall_q, wall_d, first_q, first_d;
  logic ara_ok;
  logic alert_q, heat_q, enable_q;
  logic [7:0] open_q, short_q, force_q;

  // Address decode of the byte just received.
  wire [7:0] ara_tx_w = {`LFAL_ALL_PREFIX, id_s, 1'b1};
  wire is_ara = (sh_q == `LFAL_ARA_READ) & alert_q; // [R17] [R2]
  wire is_allw = (sh_q == {`LFAL_ALL_PREFIX, id_s, 1'b0});
  wire is_onew = (sh_q == {`LFAL_ONE_PREFIX, id_s, 1'b0});
  wire is_oner = (sh_q == {`LFAL_ONE_PREFIX, id_s, 1'b1});
  wire [7:0] rd_byte_w = {open_q[wch_q], short_q[wch_q], read_cfg_in}; // [R16]
  wire lost_w = (md_q == MD_ARA) & ~oe_q & ~sda_s; // [R3]

  always_comb begin
    st_d = st_q;
    md_d = md_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    oe_d = oe_q;
    pend_d = pend_q;
    wall_d = wall_q;
    wdat_d = wdat_q;
    wch_d = wch_q;
    first_d = first_q;
    ara_ok = 1'b0;
    if (stop_w) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      pend_d = 1'b0;
    end else if (start_w) begin
      st_d = ST_ADDR;
      md_d = MD_NONE;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        ST_ADDR: begin
          if (rise_w) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (fall_w && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            if (!enable_q) begin
              st_d = ST_SKIP;
            end else if (is_ara || is_allw || is_onew || is_oner) begin
              oe_d = 1'b1;
              st_d = ST_AACK;
              md_d = is_ara ? MD_ARA : is_allw ? MD_ALLW :
                     is_onew ? MD_ONEW : MD_ONER;
            end else begin
              st_d = ST_SKIP;
            end
          end
        end
        ST_AACK: begin
          if (fall_w) begin
            if (md_q == MD_ARA || md_q == MD_ONER) begin
              sh_d = (md_q == MD_ARA) ? ara_tx_w : rd_byte_w;
              oe_d = (md_q == MD_ARA) ? ~ara_tx_w[7] : ~rd_byte_w[7];
              cnt_d = 4'h1;
              st_d = ST_TX;
            end else begin
              oe_d = 1'b0;
              first_d = 1'b1;
              st_d = ST_DATA;
            end
          end
        end
        ST_TX: begin
          if (rise_w && lost_w) begin
            st_d = ST_SKIP; // [R3]
          end else if (fall_w) begin
            if (cnt_q == 4'h8) begin
              oe_d = 1'b0;
              st_d = ST_TACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (rise_w) begin
            ara_ok = (md_q == MD_ARA);
            st_d = ST_SKIP;
          end
        end
        ST_DATA: begin
          if (rise_w) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (fall_w && cnt_q == 4'h8) begin
            oe_d = 1'b1;
            st_d = ST_DACK;
            if (first_q) begin
              pend_d = 1'b1;
              wall_d = (md_q == MD_ALLW);
              if (md_q == MD_ALLW) begin
                wdat_d = sh_q;
              end else begin
                wch_d = sh_q[6:4];
              end
            end
            first_d = 1'b0;
          end
        end
        ST_DACK: begin
          if (fall_w) begin
            oe_d = 1'b0;
            cnt_d = 4'h0;
            st_d = ST_DATA;
          end
        end
        ST_IDLE, ST_SKIP: begin
          oe_d = 1'b0;
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= ST_IDLE;
      md_q <= MD_NONE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      oe_q <= 1'b0;
      pend_q <= 1'b0;
      wall_q <= 1'b0;
      wdat_q <= 8'h00;
      wch_q <= 3'h0;
      first_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      st_q <= st_d;
      md_q <= md_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      oe_q <= oe_d;
      pend_q <= pend_d;
      wall_q <= wall_d;
      wdat_q <= wdat_d;
      wch_q <= wch_d;
      first_q <= first_d;
    end
  end

  // Fault flags: sets always win over clears made at STOP.
  wire apply_w = stop_w & pend_q; // [R11]
  wire [7:0] ch_sel_w = wall_q ? 8'hFF : (8'h01 << wch_q);
  wire [7:0] open_now_w = ovp_s | othr_s;
  wire heat_clr_w = apply_w & wall_q & (wdat_q == `LFAL_HEAT_CLEAR) &
                    tok_s; // [R14] [R15]
  wire [7:0] clr_o_w = heat_q ? {8{heat_clr_w}} :
                       {8{apply_w}} & ch_sel_w & ~open_now_w; // [R12]
  wire [7:0] clr_s_w = heat_q ? {8{heat_clr_w}} :
                       {8{apply_w}} & ch_sel_w & ~sthr_s; // [R12]
  wire [7:0] set_o_w = ovp_s | oq_w | {8{heat_s}}; // [R6] [R13]
  wire [7:0] set_s_w = sq_w | {8{heat_s}}; // [R9] [R13]
  wire [7:0] open_d = (open_q & ~clr_o_w) | set_o_w; // [R7]
  wire [7:0] short_d = (short_q & ~clr_s_w) | set_s_w; // [R10]
  wire [7:0] force_d = (force_q & ~clr_o_w) | set_o_w; // [R7] [R8]
  wire ev_o_w = |(set_o_w & ~open_q);
  wire ev_s_w = |(set_s_w & ~short_q);
  wire ev_h_w = heat_s & ~heat_q;
  wire new_ev_w = ev_o_w | ev_s_w | ev_h_w;
  wire alert_d = new_ev_w ? 1'b1 : // [R7] [R10] [R13]
                 apply_w ? |(open_d | short_d) : // [R12] [R15]
                 ara_ok ? 1'b0 : alert_q; // [R4] [R5]

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      open_q <= 8'h00;
      short_q <= 8'h00;
      force_q <= 8'h00;
      heat_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      open_q <= open_d;
      short_q <= short_d;
      force_q <= force_d;
      heat_q <= heat_s | (heat_q & ~heat_clr_w);
      alert_q <= alert_d;
    end
  end

  // Avalon-MM slave with one wait state per access.
  logic ack_q, enable_q_d;
  logic [4:0] status_q, mask_q;
  logic [31:0] rdata_q, rdata_d;
  wire req_w = avs_read_in | avs_write_in;
  wire wr_w = avs_write_in & ack_q;
  wire [4:0] ev_w = {apply_w, ara_ok, ev_h_w, ev_s_w, ev_o_w};
  wire w1c_w = wr_w & (avs_address_in == `LFAL_OFS_IRQ_STATUS);
  wire [4:0] w1c_bits_w = {5{w1c_w}} & avs_writedata_in[4:0];
  wire wmask_w = wr_w & (avs_address_in == `LFAL_OFS_IRQ_MASK);
  wire wctl_w = wr_w & (avs_address_in == `LFAL_OFS_CONTROL);
  assign enable_q_d = wctl_w ? avs_writedata_in[0] : enable_q;
  always_comb begin
    case (avs_address_in)
      `LFAL_OFS_IRQ_STATUS: rdata_d = {27'h0, status_q};
      `LFAL_OFS_IRQ_MASK: rdata_d = {27'h0, mask_q};
      `LFAL_OFS_OPEN_FLAGS: rdata_d = {24'h0, open_q};
      `LFAL_OFS_SHORT_FLAGS: rdata_d = {24'h0, short_q};
      `LFAL_OFS_STATE: rdata_d = {22'h0, heat_q, alert_q, force_q};
      `LFAL_OFS_CONTROL: rdata_d = {31'h0, enable_q};
      default: rdata_d = 32'h0;
    endcase
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      status_q <= 5'h00;
      mask_q <= `LFAL_RST_MASK;
      enable_q <= `LFAL_RST_CONTROL;
    end else begin
      ack_q <= req_w & ~ack_q;
      if (avs_read_in && !ack_q) begin
        rdata_q <= rdata_d;
      end
      status_q <= (status_q & ~w1c_bits_w) | ev_w;
      if (wmask_w) begin
        mask_q <= avs_writedata_in[4:0];
      end
      enable_q <= enable_q_d;
    end
  end

  assign avs_waitrequest_out = req_w & ~ack_q;
  assign avs_readdata_out = rdata_q;
  assign irq_out = |(status_q & mask_q);
  assign sda_out = 1'b0;
  assign sda_oe_out = oe_q;
  assign alert_n_out = 1'b0; // [R19]
  assign alert_oe_out = alert_q; // [R19]
  assign cfg_channel_out = wch_q;
  assign switch_force_on_out = force_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  ara_no_ack_a: assert property ( // [R17]
    st_q == ST_ADDR && fall_w && cnt_q == 4'h8 &&
    sh_q == `LFAL_ARA_READ && !alert_q |=> !sda_oe_out)
    else $error("alert read acknowledged without alert");
  arb_abort_a: assert property ( // [R3]
    st_q == ST_TX && rise_w && lost_w && !stop_w && !start_w
    |=> st_q == ST_SKIP && !sda_oe_out)
    else $error("arbitration loss did not abort");
  ara_release_a: assert property ( // [R4]
    ara_ok && !new_ev_w && !apply_w |=> !alert_oe_out)
    else $error("alert kept after alert response");
  ara_flags_a: assert property ( // [R5]
    ara_ok |=> (open_q & $past(open_q)) == $past(open_q) &&
               (short_q & $past(short_q)) == $past(short_q))
    else $error("alert response changed flags");
  open_fault_a: assert property ( // [R6]
    ovp_s != 8'h00 |=> (open_q & force_q & $past(ovp_s)) == $past(ovp_s)
                       && alert_oe_out)
    else $error("open fault not latched");
  short_fault_a: assert property ( // [R9]
    sq_w != 8'h00 |=> (short_q & $past(sq_w)) == $past(sq_w))
    else $error("short fault not latched");
  flag_hold_a: assert property ( // [R11]
    !apply_w |=> (open_q & $past(open_q)) == $past(open_q) &&
                 (short_q & $past(short_q)) == $past(short_q))
    else $error("flag cleared without write");
  heat_all_a: assert property ( // [R13]
    heat_s |=> open_q == 8'hFF && short_q == 8'hFF &&
               switch_force_on_out == 8'hFF && alert_oe_out)
    else $error("overheat did not set all");
  heat_keep_a: assert property ( // [R14]
    heat_q && !heat_clr_w |=> heat_q && open_q == 8'hFF)
    else $error("overheat flags dropped");

  ara_done_c: cover property (ara_ok);
  arb_lost_c: cover property (st_q == ST_TX && rise_w && lost_w);
  stop_clear_c: cover property (apply_w && clr_o_w != 8'h00);
  heat_clear_c: cover property (heat_clr_w);
endmodule
`default_nettype wire

// [testbench/lfal_bus_master_model.sv]
/*
  Behavioural serial bus master that stands on the far side of the alert
  logic. Assumes a wired-AND SDA level fed back on sda_in and SCL paced
  from clk_in at 200 ns per bit, idle high between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module lfal_bus_master_model (
  // Pacing clock.
  input wire logic clk_in,
  // Wired SDA level.
  input wire logic sda_in,
  // Driven pins; sda_oe_out high pulls SDA low.
  output logic scl_out,
  output logic sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic q();
    repeat (2) @(posedge clk_in);
  endtask
  task automatic start();
    q();
    sda_oe_out <= 1'b1;
    q();
    q();
    scl_out <= 1'b0;
  endtask
  // SDA only changes while SCL is low; it is sampled at the end of high.
  // SCL stays low for six clocks and high for two, so the device's answer,
  // which trails each SCL fall by about five clocks, settles while SCL is
  // still low.
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_oe_out <= ~b;
    q();
    q();
    scl_out <= 1'b1;
    q();
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    q();
    sda_oe_out <= 1'b1;
    q();
    scl_out <= 1'b1;
    q();
    q();
    sda_oe_out <= 1'b0;
    q();
    q();
  endtask
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // A set bit of pull stands in for a rival device pulling SDA low.
  task automatic byte_rx(input logic [7:0] pull, input logic mack,
                         output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(~pull[i], d[i]);
    bit_io(~mack, r);
  endtask
endmodule
`default_nettype wire

// [testbench/test_lfal_alert_logic.sv]
/*
  Self-checking bench of the LED fault alert logic.
  Assumes the design's register map header and the bus master model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lfal_regs.svh"
module test_lfal_alert_logic
  import lfal_pkg::*;
;
  localparam int QC = 8;
  logic clk_in, reset_n_in, avs_read_in, avs_write_in, scl, m_oe, sda_w;
  logic [4:0] avs_address_in;
  logic [31:0] avs_writedata_in, rdata, seed, q;
  logic wreq, irq, sda_o, sda_oe, alert_n, alert_oe, ot, tok, ack;
  logic [3:0] id;
  logic [7:0] ovp, thr, sh, force_on, got, eo, es, a_all, a_one;
  logic [5:0] cfg;
  logic [2:0] cfg_ch, ch, ch2, ch3;
  int n_mismatch, check_count;
  assign sda_w = ~(m_oe | sda_oe);
  lfal_alert_logic #(.CHANNELS(8), .QUAL_CYCLES(QC)) DUT (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .irq_out(irq),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .bus_id_select_pins_in(id), .alert_n_out(alert_n),
    .alert_oe_out(alert_oe), .open_ovp_in(ovp), .open_thr_in(thr),
    .short_thr_in(sh), .overtemp_in(ot), .temp_ok_in(tok),
    .read_cfg_in(cfg), .cfg_channel_out(cfg_ch),
    .switch_force_on_out(force_on)
  );
  lfal_bus_master_model m (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl),
    .sda_oe_out(m_oe));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] ara_reply(input logic [3:0] a);
    return {3'b010, a, 1'b1};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= ~w;
    avs_write_in <= w;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0);
    v = rdata;
    chk(n, 32'h2);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask
  task automatic lv(input logic [7:0] o, t, s, input int n);
    @(posedge clk_in);
    ovp <= o;
    thr <= t;
    sh <= s;
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic xfer(input logic [7:0] a, d, pull);
    logic r;
    m.start();
    m.byte_tx(a, ack);
    if (ack === 1'b1 && a[0])
      m.byte_rx(pull, 1'b1, got);
    else if (ack === 1'b1)
      m.byte_tx(d, r);
    m.stop();
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
  initial begin
    seed = 32'h1BF44FDA;
    n_mismatch = 0;
    check_count = 0;
    reset_n_in = 1'b0;
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
    {ovp, thr, sh, ot, tok} = {24'h0, 1'b0, 1'b1};
    q = rnd();
    {id, cfg, ch} = q[12:0];
    ch2 = ch ^ 3'h1;
    ch3 = ch ^ 3'h2;
    a_all = {3'b010, id, 1'b0};
    a_one = {3'b101, id, 1'b0};
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(`LFAL_OFS_IRQ_MASK, 32'h0);
    rd(`LFAL_OFS_CONTROL, 32'h1);
    wr(5'h18, 32'hFFFFFFFF);
    rd(5'h18, 32'h0);
    xfer(8'h19, 8'h00, 8'h00);
    chk(ack, 1'b0);
    lv(8'h00, 8'h00, 8'h01 << ch, 6);
    lv(8'h00, 8'h00, 8'h00, 2);
    lv(8'h00, 8'h00, 8'h01 << ch, 6);
    lv(8'h00, 8'h00, 8'h00, 12);
    rd(`LFAL_OFS_SHORT_FLAGS, 32'h0);
    lv(8'h00, 8'h00, 8'h01 << ch, QC + 12);
    lv(8'h00, 8'h00, 8'h00, 4);
    es = 8'h01 << ch;
    rd(`LFAL_OFS_SHORT_FLAGS, {24'h0, es});
    chk(alert_oe, 1'b1);
    chk(force_on, 8'h00);
    rd(`LFAL_OFS_IRQ_STATUS, 32'h2);
    chk(irq, 1'b0);
    wr(`LFAL_OFS_IRQ_MASK, 32'h1F);
    chk(irq, 1'b1);
    wr(`LFAL_OFS_IRQ_STATUS, 32'h1F);
    chk(irq, 1'b0);
    // The overvoltage pulse is shorter than the qualification time.
    lv(8'h01 << ch2, 8'h00, 8'h00, 2);
    lv(8'h00, 8'h01 << ch, 8'h00, QC + 12);
    lv(8'h00, 8'h00, 8'h00, 4);
    eo = (8'h01 << ch2) | (8'h01 << ch);
    rd(`LFAL_OFS_OPEN_FLAGS, {24'h0, eo});
    rd(`LFAL_OFS_STATE, {22'h0, 2'b01, eo});
    // With the bus responder disabled even the alert read goes unanswered.
    wr(`LFAL_OFS_CONTROL, 32'h0);
    xfer(8'h19, 8'h00, 8'h00);
    chk(ack, 1'b0);
    chk(alert_oe, 1'b1);
    wr(`LFAL_OFS_CONTROL, 32'h1);
    xfer(8'h19, 8'h00, 8'h00);
    chk(ack, 1'b1);
    chk(got, ara_reply(id));
    chk(alert_oe, 1'b0);
    rd(`LFAL_OFS_OPEN_FLAGS, {24'h0, eo});
    rd(`LFAL_OFS_SHORT_FLAGS, {24'h0, es});
    xfer(8'h19, 8'h00, 8'h00);
    chk(ack, 1'b0);
    lv(8'h00, 8'h00, 8'h01 << ch2, QC + 12);
    lv(8'h00, 8'h00, 8'h00, 4);
    es = es | (8'h01 << ch2);
    chk(alert_oe, 1'b1);
    xfer(8'h19, 8'h00, 8'h40);
    chk(got, 8'h3F);
    chk(alert_oe, 1'b1);
    xfer(8'h19, 8'h00, 8'h00);
    chk(got, ara_reply(id));
    xfer(a_one, {1'b0, ch3, 4'h0}, 8'h00);
    rd(`LFAL_OFS_OPEN_FLAGS, {24'h0, eo});
    rd(`LFAL_OFS_SHORT_FLAGS, {24'h0, es});
    lv(8'h00, 8'h00, 8'h01 << ch, QC + 12);
    xfer(a_one, {1'b0, ch, 4'h0}, 8'h00);
    eo = eo & ~(8'h01 << ch);
    rd(`LFAL_OFS_OPEN_FLAGS, {24'h0, eo});
    rd(`LFAL_OFS_SHORT_FLAGS, {24'h0, es});
    chk(force_on, eo);
    chk(alert_oe, 1'b1);
    chk(cfg_ch, ch);
    xfer({3'b101, id, 1'b1}, 8'h00, 8'h00);
    chk(got, {2'b01, cfg});
    lv(8'h00, 8'h00, 8'h00, 4);
    q = rnd();
    xfer(a_all, q[7:0] & 8'hFE, 8'h00);
    rd(`LFAL_OFS_OPEN_FLAGS, 32'h0);
    rd(`LFAL_OFS_SHORT_FLAGS, 32'h0);
    chk(alert_oe, 1'b0);
    chk(force_on, 8'h00);
    @(posedge clk_in);
    ot <= 1'b1;
    tok <= 1'b0;
    repeat (4) @(posedge clk_in);
    ot <= 1'b0;
    repeat (12) @(posedge clk_in);
    rd(`LFAL_OFS_STATE, 32'h3FF);
    rd(`LFAL_OFS_SHORT_FLAGS, 32'hFF);
    xfer(a_all, 8'hFE, 8'h00);
    rd(`LFAL_OFS_STATE, 32'h3FF);
    xfer(a_all, 8'hFF, 8'h00);
    rd(`LFAL_OFS_STATE, 32'h3FF);
    @(posedge clk_in);
    tok <= 1'b1;
    xfer(a_all, 8'hFF, 8'h00);
    rd(`LFAL_OFS_STATE, 32'h0);
    rd(`LFAL_OFS_OPEN_FLAGS, 32'h0);
    chk({alert_n, sda_o}, 2'b00);
    results();
  end
endmodule
`default_nettype wire
